// [inc/csc_pkg.sv]
package csc_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] CSC_CONTROL_ADDR = 8'hB0;
    localparam logic [7:0] CSC_CONTROL_RESET = 8'h00;

    // ************************************************************
    // Field positions of the control register
    // ************************************************************
    localparam int CSC_BIT_ENABLE = 7;
    localparam int CSC_BIT_EOS = 6;
    localparam int CSC_BIT_DONE = 5;
    localparam int CSC_BIT_BUSY = 4;
    localparam int CSC_BIT_CMPEN = 3;
    localparam int CSC_BIT_PME = 1;
    localparam int CSC_BIT_CMPF = 0;

    // ************************************************************
    // Start modes and flag indices
    // ************************************************************
    localparam logic [2:0] CSC_MODE_SOFTWARE = 3'h0;
    localparam int CSC_NUM_FLAGS = 4;
    localparam int CSC_FLAG_EOS = 0;
    localparam int CSC_FLAG_DONE = 1;
    localparam int CSC_FLAG_PME = 2;
    localparam int CSC_FLAG_CMPF = 3;

    // Events reported by the converter core, same clock
    typedef struct packed {
        logic conv_done;
        logic scan_done;
        logic retry;
        logic [15:0] result;
    } csc_event_t;

    // Register bus access
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } csc_sfr_req_t;

    typedef enum logic {
        CSC_IDLE = 1'b0,
        CSC_BUSY = 1'b1
    } csc_state_t;

endpackage : csc_pkg

// [src/csc_flag.sv]
`timescale 1ns/1ps

// Sticky flag: hardware set beats a software clear in the same cycle
module csc_flag (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hw_set,
    input wire logic sw_set,
    input wire logic sw_clr,
    output logic flag_q
);

    logic flag_d;

    // ************************************************************
    // Next value
    // ************************************************************
    always_comb begin
        flag_d = flag_q;
        if (sw_clr) begin
            flag_d = 1'b0;
        end
        // Set last so a coincident event is never lost
        if (hw_set || sw_set) begin
            flag_d = 1'b1;
        end
    end

    // Register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

endmodule : csc_flag

// [src/csc_control.sv]
`timescale 1ns/1ps

// Summary of operation
// - Enable bit 7 low holds converter in low power; high lets it convert.
// - End-of-scan flag bit 6 sets on scan finish, only software or reset clears it.
// - Conversion-done flag bit 5 sets on each conversion, only software or reset clears it.
// - Busy bit 4 reads one while a conversion runs, zero otherwise.
// - Comparator enable bit 3 switches the greater-than threshold comparator.
// - In software start mode a write of one to busy starts a conversion only while enabled and idle.
// - Pin-monitor event bit sets on any retry, cleared by software or reset.
module csc_control (
    input wire logic sys_clk,
    input wire logic rst,
    input wire csc_pkg::csc_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata_q,
    input wire csc_pkg::csc_event_t conv_event,
    input wire logic [2:0] start_mode_select,
    input wire logic hw_start,
    input wire logic [15:0] threshold,
    output logic sense_enable_q,
    output logic low_power_q,
    output logic conv_start_q,
    output logic comparator_enable_q
);

    // ************************************************************
    // Register decode
    // ************************************************************
    logic sel_wr;
    logic enable_d;
    logic cmpen_d;
    logic start_d;
    logic [7:0] rdata_d;
    logic [csc_pkg::CSC_NUM_FLAGS-1:0] flag_set;
    logic [csc_pkg::CSC_NUM_FLAGS-1:0] flag_sw_set;
    logic [csc_pkg::CSC_NUM_FLAGS-1:0] flag_clr;
    logic [csc_pkg::CSC_NUM_FLAGS-1:0] flag_q;
    logic [csc_pkg::CSC_NUM_FLAGS-1:0] clr_bits;
    csc_pkg::csc_state_t state_q;
    csc_pkg::csc_state_t state_d;

    // Only the control register address is decoded; every other address is ignored
    assign sel_wr = sfr_req.wr && (sfr_req.addr == csc_pkg::CSC_CONTROL_ADDR);

    // ************************************************************
    // Control bits
    // ************************************************************
    always_comb begin
        enable_d = sense_enable_q;
        cmpen_d = comparator_enable_q;
        if (sel_wr) begin
            enable_d = sfr_req.wdata[csc_pkg::CSC_BIT_ENABLE];
            cmpen_d = sfr_req.wdata[csc_pkg::CSC_BIT_CMPEN];
        end
    end

    // ************************************************************
    // Conversion sequencing
    // ************************************************************
    // Two states only: the core owns timing, we only track busy.
    // A start written while busy is dropped, not queued, so software
    // must poll busy or wait for the done flag before the next start.
    // The start pulse lasts one cycle; the core must latch it.
    // Hardware starts use the same path, gated by the mode field.
    always_comb begin
        state_d = state_q;
        start_d = 1'b0;
        unique case (state_q)
            csc_pkg::CSC_IDLE: begin
                // Start only while enabled; a start while idle-disabled is dropped
                if (sense_enable_q) begin
                    if (start_mode_select == csc_pkg::CSC_MODE_SOFTWARE) begin
                        start_d = sel_wr && sfr_req.wdata[csc_pkg::CSC_BIT_BUSY];
                    end else begin
                        start_d = hw_start;
                    end
                end
                if (start_d) begin
                    state_d = csc_pkg::CSC_BUSY;
                end
            end
            csc_pkg::CSC_BUSY: begin
                // Disabling aborts the conversion so busy never sticks
                if (conv_event.conv_done || !sense_enable_q) begin
                    state_d = csc_pkg::CSC_IDLE;
                end
            end
        endcase
    end

    // ************************************************************
    // Flag sources
    // ************************************************************
    always_comb begin
        clr_bits = '0;
        flag_sw_set = '0;
        flag_set[csc_pkg::CSC_FLAG_EOS] = conv_event.scan_done;
        flag_set[csc_pkg::CSC_FLAG_DONE] = conv_event.conv_done;
        flag_set[csc_pkg::CSC_FLAG_PME] = conv_event.retry;
        flag_set[csc_pkg::CSC_FLAG_CMPF] = conv_event.conv_done && comparator_enable_q
            && (conv_event.result > threshold);
        if (sel_wr) begin
            // Flags clear on a written zero; a written one leaves them alone, except done, which it sets
            clr_bits[csc_pkg::CSC_FLAG_EOS] = !sfr_req.wdata[csc_pkg::CSC_BIT_EOS];
            clr_bits[csc_pkg::CSC_FLAG_DONE] = !sfr_req.wdata[csc_pkg::CSC_BIT_DONE];
            clr_bits[csc_pkg::CSC_FLAG_PME] = !sfr_req.wdata[csc_pkg::CSC_BIT_PME];
            clr_bits[csc_pkg::CSC_FLAG_CMPF] = !sfr_req.wdata[csc_pkg::CSC_BIT_CMPF];
            // Done flag is read/write, so software may raise it for testing
            flag_sw_set[csc_pkg::CSC_FLAG_DONE] = sfr_req.wdata[csc_pkg::CSC_BIT_DONE];
        end
        flag_clr = clr_bits;
    end

    // One sticky cell per flag, set wins over clear
    // Trade-off: a write that clears a flag in the cycle of its event
    // leaves it set, so software may see the flag again after a clear.
    genvar gi;
    generate
        for (gi = 0; gi < csc_pkg::CSC_NUM_FLAGS; gi++) begin : g_flag
            csc_flag u_flag (
                .sys_clk(sys_clk),
                .rst(rst),
                .hw_set(flag_set[gi]),
                .sw_set(flag_sw_set[gi]),
                .sw_clr(flag_clr[gi]),
                .flag_q(flag_q[gi])
            );
        end
    endgenerate

    // ************************************************************
    // Read data, one cycle behind the address
    // ************************************************************
    always_comb begin
        rdata_d = 8'h00;
        if (sfr_req.addr == csc_pkg::CSC_CONTROL_ADDR) begin
            rdata_d[csc_pkg::CSC_BIT_ENABLE] = sense_enable_q;
            rdata_d[csc_pkg::CSC_BIT_EOS] = flag_q[csc_pkg::CSC_FLAG_EOS];
            rdata_d[csc_pkg::CSC_BIT_DONE] = flag_q[csc_pkg::CSC_FLAG_DONE];
            rdata_d[csc_pkg::CSC_BIT_BUSY] = (state_q == csc_pkg::CSC_BUSY);
            rdata_d[csc_pkg::CSC_BIT_CMPEN] = comparator_enable_q;
            rdata_d[csc_pkg::CSC_BIT_PME] = flag_q[csc_pkg::CSC_FLAG_PME];
            rdata_d[csc_pkg::CSC_BIT_CMPF] = flag_q[csc_pkg::CSC_FLAG_CMPF];
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    // Low power follows the next enable value so it never lags the
    // enable output by a cycle; both come straight from flip-flops.
    // Reset leaves the converter disabled and in low power.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sense_enable_q <= csc_pkg::CSC_CONTROL_RESET[csc_pkg::CSC_BIT_ENABLE];
            low_power_q <= 1'b1;
            comparator_enable_q <= csc_pkg::CSC_CONTROL_RESET[csc_pkg::CSC_BIT_CMPEN];
            conv_start_q <= 1'b0;
            state_q <= csc_pkg::CSC_IDLE;
            sfr_rdata_q <= 8'h00;
        end else begin
            sense_enable_q <= enable_d;
            low_power_q <= !enable_d;
            comparator_enable_q <= cmpen_d;
            conv_start_q <= start_d;
            state_q <= state_d;
            sfr_rdata_q <= rdata_d;
        end
    end

endmodule : csc_control

// [dv/csc_core_model.sv]
`timescale 1ns/1ps
// ****
// Converter core stand-in
// ****
module csc_core_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [3:0] delay,
    input wire logic [15:0] res,
    output csc_pkg::csc_event_t ev
);
    initial ev = '0;
    // Starts busy work; result valid only with done, scrambled otherwise
    always @(posedge sys_clk) begin
        if (!rst && start) begin
            repeat (delay) @(posedge sys_clk);
            #1 ev = {3'b111, res};
            @(posedge sys_clk);
            #1 ev = {3'b000, ~res};
        end
    end
endmodule : csc_core_model

// [dv/csc_control_monitor.sv]
`timescale 1ns/1ps
// ****
// Port checks
// ****
module csc_control_monitor (
    input wire logic sys_clk,
    input wire logic rst,
    input wire csc_pkg::csc_sfr_req_t sfr_req,
    input wire logic [7:0] sfr_rdata_q,
    input wire csc_pkg::csc_event_t conv_event,
    input wire logic [2:0] start_mode_select,
    input wire logic hw_start,
    input wire logic [15:0] threshold,
    input wire logic sense_enable_q,
    input wire logic low_power_q,
    input wire logic conv_start_q,
    input wire logic comparator_enable_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic wr_b0;
    // Write aimed at the control register
    assign wr_b0 = sfr_req.wr && sfr_req.addr == 8'hB0;
    // Quiet cycles so no clear races the flag, then a read
    sequence s_rd;
        (!sfr_req.wr && !conv_event.conv_done)[*2] ##0 sfr_req.addr == 8'hB0;
    endsequence
    property p_lp; low_power_q != sense_enable_q; endproperty
    property p_en; wr_b0 |=> sense_enable_q == $past(sfr_req.wdata[7]); endproperty
    property p_cmpen; wr_b0 |=> comparator_enable_q == $past(sfr_req.wdata[3]); endproperty
    property p_start;
        conv_start_q && start_mode_select == 3'h0 |-> $past(wr_b0 && sfr_req.wdata[4] && sense_enable_q);
    endproperty
    property p_eos; conv_event.scan_done ##1 s_rd |=> sfr_rdata_q[6]; endproperty
    property p_done; conv_event.conv_done ##1 s_rd |=> sfr_rdata_q[5]; endproperty
    property p_busy; (conv_start_q && !conv_event.conv_done) ##1 s_rd |=> sfr_rdata_q[4]; endproperty
    property p_pme; conv_event.retry ##1 s_rd |=> sfr_rdata_q[1]; endproperty
    property p_cmpf;
        (conv_event.conv_done && comparator_enable_q && conv_event.result > threshold) ##1 s_rd |=> sfr_rdata_q[0];
    endproperty
    a_lp: assert property (p_lp) else $error("low power wrong");
    a_en: assert property (p_en) else $error("enable wrong");
    a_cmpen: assert property (p_cmpen) else $error("cmp enable wrong");
    a_start: assert property (p_start) else $error("bad start");
    a_eos: assert property (p_eos) else $error("scan flag lost");
    a_done: assert property (p_done) else $error("done flag lost");
    a_busy: assert property (p_busy) else $error("busy low");
    a_pme: assert property (p_pme) else $error("retry flag lost");
    a_cmpf: assert property (p_cmpf) else $error("cmp flag lost");
endmodule : csc_control_monitor
bind csc_control csc_control_monitor i_mon (.sys_clk(sys_clk), .rst(rst), .sfr_req(sfr_req),
    .sfr_rdata_q(sfr_rdata_q), .conv_event(conv_event), .start_mode_select(start_mode_select),
    .hw_start(hw_start), .threshold(threshold), .sense_enable_q(sense_enable_q),
    .low_power_q(low_power_q), .conv_start_q(conv_start_q), .comparator_enable_q(comparator_enable_q));

// [dv/testbench.sv]
`timescale 1ns/1ps
// ****
// Register-level tests
// ****
module testbench;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    csc_pkg::csc_sfr_req_t req = '{1'b0, 8'hB0, 8'h00};
    csc_pkg::csc_event_t ev;
    logic [7:0] rdata;
    logic en, lp, start, cmpen;
    logic [3:0] dly = 4'h8;
    logic [15:0] res = 16'h2000;
    logic [2:0] mode = 3'h0;
    logic hws = 1'b0;
    int n_errors = 0;
    int tests_run = 0;
    // Free-running 50 MHz clock
    initial forever #10 sys_clk = ~sys_clk;
    csc_control i_csc_control (.sys_clk(sys_clk), .rst(rst), .sfr_req(req), .sfr_rdata_q(rdata),
        .conv_event(ev), .start_mode_select(mode), .hw_start(hws), .threshold(16'h1000),
        .sense_enable_q(en), .low_power_q(lp), .conv_start_q(start), .comparator_enable_q(cmpen));
    csc_core_model i_csc_core_model (.sys_clk(sys_clk), .rst(rst), .start(start), .delay(dly),
        .res(res), .ev(ev));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic test_done;
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done
    task automatic wr(input logic [7:0] d);
        @(posedge sys_clk);
        #1 req = '{1'b1, req.addr, d};
        @(posedge sys_clk);
        #1 req.wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] exp);
        @(posedge sys_clk);
        #1 check(rdata, exp);
    endtask : rd
    // Bounded wait for the core to finish
    task automatic wait_done;
        int i;
        for (i = 0; i < 40 && ev.conv_done !== 1'b1; i++) @(posedge sys_clk);
        if (i == 40) begin
            n_errors++;
            test_done;
        end
        @(posedge sys_clk);
        #1;
    endtask : wait_done
    // Main sequence; a start needs enable already set
    initial begin
        repeat (10) @(posedge sys_clk);
        #1 rst = 1'b0;
        rd(8'h00);
        check(8'(lp), 8'h01);
        wr(8'h90);
        rd(8'h80);
        check(8'(lp), 8'h00);
        wr(8'h98);
        rd(8'h98);
        check(8'(cmpen), 8'h01);
        wait_done;
        rd(8'hEB);
        repeat (5) @(posedge sys_clk);
        rd(8'hEB);
        wr(8'h88);
        rd(8'h88);
        dly = 4'h1;
        res = 16'h1000;
        wr(8'h98);
        wait_done;
        rd(8'hEA);
        req.addr = 8'h55;
        wr(8'h00);
        rd(8'h00);
        req.addr = 8'hB0;
        rd(8'hEA);
        wr(8'h00);
        wr(8'h10);
        rd(8'h00);
        mode = 3'h1;
        wr(8'h80);
        wr(8'h90);
        rd(8'h80);
        hws = 1'b1;
        @(posedge sys_clk);
        #1 hws = 1'b0;
        rd(8'h90);
        test_done;
    end
endmodule : testbench
